//--- core/uart_rx_status.sv
// receive path with status flags, threshold flag and apb registers
`timescale 1ns/1ps
`default_nettype none
module uart_rx_status
  import uart_rx_status_pkg::*;
#(
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic CLOCK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // serial line and status
  input wire logic RX_PIN,
  output logic RX_IRQ_FLAG,
  output logic ADDRESS_CHAR_SEEN
);
  localparam int AW = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////
  // apb decode
  wire wr_en = PSEL && PENABLE && PWRITE;
  wire rd_en = PSEL && PENABLE && !PWRITE;
  wire hit_sta = PADDR == STA_OFFSET;
  wire hit_mode = PADDR == MODE_OFFSET;
  wire hit_data = PADDR == RXDATA_OFFSET;
  wire hit_baud = PADDR == BAUD_OFFSET;
  wire mapped = hit_sta || hit_mode || hit_data || hit_baud;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !mapped;

  logic [1:0] rx_irq_threshold_select_q;
  logic address_char_detect_enable_q;
  logic receiver_enable_bit_q;
  logic [1:0] parity_data_format_select_q;
  logic stop_two_q;
  logic [15:0] baud_div_q;
  logic overrun_error_flag_q;

  wire sta_wr = wr_en && hit_sta;
  // a zero written over a set overrun flag is the clear event
  wire overrun_error_flag_clear = sta_wr && !PWDATA[STA_OVERRUN_ERROR_FLAG_BIT] && overrun_error_flag_q;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_irq_threshold_select_q <= THR_ONE;
      address_char_detect_enable_q <= 1'b0;
      receiver_enable_bit_q <= 1'b0;
      parity_data_format_select_q <= FMT_NOPAR;
      stop_two_q <= 1'b0;
      baud_div_q <= BAUD_RESET;
    end else begin
      if (sta_wr) begin
        rx_irq_threshold_select_q <= PWDATA[STA_THR_LSB +: 2];
        address_char_detect_enable_q <= PWDATA[STA_ADDRESS_CHAR_DETECT_ENABLE_BIT];
        receiver_enable_bit_q <= PWDATA[STA_RXEN_BIT];
      end
      if (wr_en && hit_mode) begin
        parity_data_format_select_q <= PWDATA[MODE_FMT_LSB +: 2];
        stop_two_q <= PWDATA[MODE_STOP_BIT];
      end
      if (wr_en && hit_baud) begin
        baud_div_q <= PWDATA[15:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // line synchroniser
  logic rx_meta_q;
  logic rx_sync_q;
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      rx_meta_q <= 1'b1;
      rx_sync_q <= 1'b1;
    end else begin
      rx_meta_q <= RX_PIN;
      rx_sync_q <= rx_meta_q;
    end
  end
  // disabled receiver sees a steady idle line
  wire rx_line = receiver_enable_bit_q ? rx_sync_q : 1'b1;

  ////////////////////////////////////////////////////////////////////////
  // receive shift register
  rx_state_t state_q;
  logic [15:0] tick_cnt_q;
  logic [3:0] os_cnt_q;
  logic [3:0] bit_cnt_q;
  logic [9:0] shift_q;
  logic stop_idx_q;

  wire nine_bit = parity_data_format_select_q == FMT_NINE;
  wire has_par = parity_data_format_select_q == FMT_EVEN
      || parity_data_format_select_q == FMT_ODD;
  wire [3:0] nbits = (nine_bit || has_par) ? 4'h9 : 4'h8;
  wire tick = tick_cnt_q == baud_div_q;
  wire mid = tick && os_cnt_q == 4'(OVERSAMPLE / 2 - 1);
  wire last_os = tick && os_cnt_q == 4'(OVERSAMPLE - 1);
  wire stop_last = !stop_two_q || stop_idx_q;
  wire frame_done = state_q == RX_STOP && mid && stop_last;

  logic [AW:0] count_q;
  wire full = count_q == (AW + 1)'(DEPTH);

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      state_q <= RX_IDLE;
      tick_cnt_q <= 16'h0000;
      os_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 10'h000;
      stop_idx_q <= 1'b0;
    end else if (overrun_error_flag_clear || !receiver_enable_bit_q) begin
      state_q <= RX_IDLE;
      tick_cnt_q <= 16'h0000;
      os_cnt_q <= 4'h0;
      bit_cnt_q <= 4'h0;
      shift_q <= 10'h000;
      stop_idx_q <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      if (tick) begin
        os_cnt_q <= last_os ? 4'h0 : os_cnt_q + 4'h1;
      end
      unique case (state_q)
        RX_IDLE: begin
          tick_cnt_q <= 16'h0000;
          os_cnt_q <= 4'h0;
          // reception stays blocked while the overrun flag is set
          if (!rx_line && !overrun_error_flag_q) begin
            state_q <= RX_START;
          end
        end
        RX_START: begin
          if (mid) begin
            state_q <= rx_line ? RX_IDLE : RX_START;
          end
          if (last_os) begin
            state_q <= RX_BITS;
            bit_cnt_q <= 4'h0;
          end
        end
        RX_BITS: begin
          if (mid) begin
            shift_q <= {rx_line, shift_q[9:1]};
          end
          if (last_os) begin
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == nbits - 4'h1) begin
              state_q <= RX_STOP;
              stop_idx_q <= 1'b0;
            end
          end
        end
        RX_STOP: begin
          if (mid && !stop_last) begin
            stop_idx_q <= 1'b1;
          end
          if (frame_done) begin
            state_q <= RX_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assembled character: data, ninth bit, parity and framing status
  wire [8:0] rx_word = nbits == 4'h9 ? shift_q[9:1] : {1'b0, shift_q[9:2]};
  wire par_calc = ^rx_word[7:0] ^ (parity_data_format_select_q == FMT_ODD);
  wire par_bad = has_par && (par_calc != rx_word[8]);
  wire frm_bad = !rx_line;
  wire [8:0] rx_data = has_par ? {1'b0, rx_word[7:0]} : rx_word;
  // address detect: ninth bit marks an address, only in 9-bit mode
  wire addr_char = address_char_detect_enable_q && nine_bit && rx_word[8];
  wire push = frame_done && !full;
  wire overflow = frame_done && full;

  ////////////////////////////////////////////////////////////////////////
  // eight-entry receive buffer
  logic [10:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  wire pop = rd_en && hit_data && count_q != '0;
  wire [10:0] head = mem_q[rd_ptr_q];

  always_ff @(posedge CLOCK) begin
    if (push) begin
      mem_q[wr_ptr_q] <= {frm_bad, par_bad, rx_data};
    end
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      overrun_error_flag_q <= 1'b0;
      ADDRESS_CHAR_SEEN <= 1'b0;
    end else begin
      ADDRESS_CHAR_SEEN <= push && addr_char;
      if (overrun_error_flag_clear) begin
        wr_ptr_q <= '0;
        rd_ptr_q <= '0;
        count_q <= '0;
        overrun_error_flag_q <= 1'b0;
      end else begin
        if (push) begin
          wr_ptr_q <= wr_ptr_q + 1'b1;
        end
        if (pop) begin
          rd_ptr_q <= rd_ptr_q + 1'b1;
        end
        count_q <= count_q + (AW + 1)'(push) - (AW + 1)'(pop);
        if (overflow) begin
          overrun_error_flag_q <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // status flags and threshold
  wire data_avail = count_q != '0;
  wire idle_flag = state_q == RX_IDLE;
  wire parity_error_flag_flag = data_avail && head[9];
  wire framing_error_flag_flag = data_avail && head[10];
  logic irq_d;
  always_comb begin
    unique case (rx_irq_threshold_select_q)
      THR_HALF: irq_d = count_q >= (AW + 1)'(LEVEL_HALF);
      THR_3Q: irq_d = count_q >= (AW + 1)'(LEVEL_3Q);
      default: irq_d = data_avail;
    endcase
  end

  wire [31:0] sta_word = {19'h00000, receiver_enable_bit_q, 4'h0,
      rx_irq_threshold_select_q, address_char_detect_enable_q, idle_flag,
      parity_error_flag_flag, framing_error_flag_flag, overrun_error_flag_q, data_avail};
  wire [31:0] rd_mux = hit_sta ? sta_word
      : hit_mode ? {29'h00000000, parity_data_format_select_q, stop_two_q}
      : hit_data ? {23'h000000, head[8:0]}
      : hit_baud ? {16'h0000, baud_div_q} : 32'h00000000;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      PRDATA <= 32'h00000000;
      RX_IRQ_FLAG <= 1'b0;
    end else begin
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rd_mux : PRDATA;
      RX_IRQ_FLAG <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  chk_irq_threshold: assert property (@(posedge CLOCK) disable iff (RST)
    rx_irq_threshold_select_q == THR_3Q |=> RX_IRQ_FLAG == ($past(count_q) >= 6))
    else $error("rx irq flag disagrees with six-char threshold");
  chk_overrun_sticky: assert property (@(posedge CLOCK) disable iff (RST)
    overrun_error_flag_q && !overrun_error_flag_clear |=> overrun_error_flag_q)
    else $error("overrun flag dropped without software clear");
  chk_overrun_empty: assert property (@(posedge CLOCK) disable iff (RST)
    overrun_error_flag_clear |=> count_q == '0 && state_q == RX_IDLE)
    else $error("overrun clear did not empty the receiver");
  chk_overrun_set: assert property (@(posedge CLOCK) disable iff (RST)
    overflow |=> overrun_error_flag_q && count_q == $past(count_q) - (AW + 1)'($past(pop)))
    else $error("overflow char written or flag not set");
  chk_rx_gated: assert property (@(posedge CLOCK) disable iff (RST)
    !receiver_enable_bit_q |=> state_q == RX_IDLE)
    else $error("receiver active while disabled");
  chk_addr_nine: assert property (@(posedge CLOCK) disable iff (RST)
    ADDRESS_CHAR_SEEN |-> $past(nine_bit) && $past(address_char_detect_enable_q))
    else $error("address char flagged outside 9-bit mode");
  chk_idle_flag: assert property (@(posedge CLOCK) disable iff (RST)
    $rose(state_q == RX_START) |-> !idle_flag ##1 !sta_word[STA_IDLE_BIT])
    else $error("idle flag high during reception");
  chk_data_avail: assert property (@(posedge CLOCK) disable iff (RST)
    push |=> sta_word[STA_DA_BIT])
    else $error("data available not set after push");
  chk_error_head: assert property (@(posedge CLOCK) disable iff (RST)
    !data_avail |-> !parity_error_flag_flag && !framing_error_flag_flag)
    else $error("error flag shown with empty buffer");
  chk_irq_half: assert property (@(posedge CLOCK) disable iff (RST)
    rx_irq_threshold_select_q == THR_HALF |=> RX_IRQ_FLAG == ($past(count_q) >= LEVEL_HALF))
    else $error("rx irq flag disagrees with four-char threshold");
  chk_irq_one: assert property (@(posedge CLOCK) disable iff (RST)
    rx_irq_threshold_select_q == THR_ONE |=> RX_IRQ_FLAG == ($past(count_q) != '0))
    else $error("rx irq flag disagrees with one-char threshold");
  chk_shift_clear: assert property (@(posedge CLOCK) disable iff (RST)
    overrun_error_flag_clear |=> shift_q == 10'h000 && bit_cnt_q == 4'h0)
    else $error("overrun clear left the shift register loaded");
endmodule
`default_nettype wire

//--- core/uart_rx_status_pkg.sv
// constants for the receive status and threshold block
package uart_rx_status_pkg;
  localparam logic [11:0] STA_OFFSET = 12'h000;
  localparam logic [11:0] MODE_OFFSET = 12'h004;
  localparam logic [11:0] RXDATA_OFFSET = 12'h008;
  localparam logic [11:0] BAUD_OFFSET = 12'h00c;
  localparam int STA_THR_LSB = 6;
  localparam int STA_ADDRESS_CHAR_DETECT_ENABLE_BIT = 5;
  localparam int STA_IDLE_BIT = 4;
  localparam int STA_PARITY_ERROR_FLAG_BIT = 3;
  localparam int STA_FRAMING_ERROR_FLAG_BIT = 2;
  localparam int STA_OVERRUN_ERROR_FLAG_BIT = 1;
  localparam int STA_DA_BIT = 0;
  localparam int STA_RXEN_BIT = 12;
  localparam int MODE_FMT_LSB = 1;
  localparam int MODE_STOP_BIT = 0;
  localparam logic [1:0] THR_ONE = 2'h0;
  localparam logic [1:0] THR_HALF = 2'h1;
  localparam logic [1:0] THR_3Q = 2'h2;
  localparam logic [3:0] LEVEL_HALF = 4'h4;
  localparam logic [3:0] LEVEL_3Q = 4'h6;
  localparam logic [1:0] FMT_NOPAR = 2'h0;
  localparam logic [1:0] FMT_EVEN = 2'h1;
  localparam logic [1:0] FMT_ODD = 2'h2;
  localparam logic [1:0] FMT_NINE = 2'h3;
  localparam logic [15:0] BAUD_RESET = 16'h000f;
  localparam int OVERSAMPLE = 16;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
endpackage

//--- verification/uart_line_source.sv
// behavioural remote serial transmitter driving the receive line
`timescale 1ns/1ps
`default_nettype none
module uart_line_source #(
  parameter int BIT_CLOCKS = 16
) (
  // clock
  input wire logic CLOCK,
  // serial line, idles high
  output logic TX
);
  initial TX = 1'b1;
  // start bit, n bits lsb first, one stop level, then one idle bit time
  task automatic send(input logic [8:0] bits, input int n, input logic stop);
    for (int i = 0; i < n + 2; i++) begin
      @(posedge CLOCK);
      TX <= (i == 0) ? 1'b0 : (i > n) ? stop : bits[i-1];
      repeat (BIT_CLOCKS - 1) @(posedge CLOCK);
    end
    @(posedge CLOCK);
    TX <= 1'b1;
    repeat (BIT_CLOCKS) @(posedge CLOCK);
  endtask
endmodule
`default_nettype wire

//--- verification/tb.sv
// self-checking bench for the receive status and threshold block
`timescale 1ns/1ps
`default_nettype none
module tb;
  import uart_rx_status_pkg::*;
  logic CLOCK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, RX_PIN, RX_IRQ_FLAG;
  logic ADDRESS_CHAR_SEEN, serr;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  int err_count, tests_run, hits;
  uart_rx_status #(.DEPTH(8)) dut(.CLOCK(CLOCK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RX_PIN(RX_PIN), .RX_IRQ_FLAG(RX_IRQ_FLAG),
    .ADDRESS_CHAR_SEEN(ADDRESS_CHAR_SEEN));
  uart_line_source #(.BIT_CLOCKS(16)) src(.CLOCK(CLOCK), .TX(RX_PIN));
  always #2.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (ADDRESS_CHAR_SEEN === 1'b1) hits <= hits + 1;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // receiver on; threshold codes 00..10 only, bit1 written from keep
  task automatic ctl(input logic [1:0] thr, input logic ad, input logic keep);
    apb(1, STA_OFFSET, (32'h1 << STA_RXEN_BIT) | (32'(thr) << STA_THR_LSB) |
      (32'(ad) << STA_ADDRESS_CHAR_DETECT_ENABLE_BIT) | (32'(keep) << STA_OVERRUN_ERROR_FLAG_BIT));
  endtask
  task automatic fmt(input logic [1:0] f);
    apb(1, MODE_OFFSET, 32'(f) << MODE_FMT_LSB);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    apb(0, STA_OFFSET, 0);
    chk("sta reset", 32'h1 << STA_IDLE_BIT, rd);
    apb(0, 12'h010, 0);
    chk("unmapped err", 1, serr);
    chk("unmapped data", 0, rd);
    apb(1, BAUD_OFFSET, 0);
    src.send(9'h0a5, 8, 1);
    apb(0, STA_OFFSET, 0);
    chk("disabled da", 0, rd[STA_DA_BIT]);
  endtask
  task automatic t_basic;
    fmt(FMT_NOPAR);
    ctl(THR_ONE, 0, 0);
    fork
      src.send(9'h0a5, 8, 1);
      begin
        repeat (60) @(posedge CLOCK);
        apb(0, STA_OFFSET, 0);
        chk("busy idle", 0, rd[STA_IDLE_BIT]);
      end
    join
    chk("irq one", 1, RX_IRQ_FLAG);
    apb(0, STA_OFFSET, 0);
    chk("da one", 3'b101, {rd[STA_IDLE_BIT], rd[STA_OVERRUN_ERROR_FLAG_BIT], rd[STA_DA_BIT]});
    apb(0, RXDATA_OFFSET, 0);
    chk("data", 32'h0a5, rd);
    apb(0, STA_OFFSET, 0);
    chk("da empty", 0, rd[STA_DA_BIT]);
    chk("irq empty", 0, RX_IRQ_FLAG);
  endtask
  task automatic t_fill;
    ctl(THR_HALF, 0, 0);
    for (int i = 0; i < 9; i++) begin
      src.send(9'(8'h30 + i), 8, 1);
      if (i == 2) chk("irq three", 0, RX_IRQ_FLAG);
      if (i == 3) begin
        chk("irq four", 1, RX_IRQ_FLAG);
        ctl(THR_3Q, 0, 0);
        repeat (2) @(posedge CLOCK);
        chk("irq four 3q", 0, RX_IRQ_FLAG);
      end
      if (i == 5) chk("irq six", 1, RX_IRQ_FLAG);
      apb(0, STA_OFFSET, 0);
      chk("overrun_error_flag", i == 8, rd[STA_OVERRUN_ERROR_FLAG_BIT]);
    end
    apb(0, RXDATA_OFFSET, 0);
    chk("head kept", 32'h30, rd);
    ctl(THR_3Q, 0, 1);
    apb(0, STA_OFFSET, 0);
    chk("overrun_error_flag write one", 3'b111, {rd[STA_OVERRUN_ERROR_FLAG_BIT], rd[STA_DA_BIT], RX_IRQ_FLAG});
    ctl(THR_ONE, 0, 0);
    apb(0, STA_OFFSET, 0);
    chk("overrun_error_flag cleared", 3'b000, {rd[STA_OVERRUN_ERROR_FLAG_BIT], rd[STA_DA_BIT], RX_IRQ_FLAG});
    src.send(9'h05c, 8, 1);
    apb(0, RXDATA_OFFSET, 0);
    chk("after clear", 32'h05c, rd);
  endtask
  task automatic t_errors;
    fmt(FMT_EVEN);
    src.send({1'b1, 8'h03}, 9, 1);
    src.send({1'b1, 8'h07}, 9, 0);
    for (int i = 0; i < 3; i++) begin
      apb(0, STA_OFFSET, 0);
      chk("parity_error_flag head", i == 0, rd[STA_PARITY_ERROR_FLAG_BIT]);
      chk("framing_error_flag head", i == 1, rd[STA_FRAMING_ERROR_FLAG_BIT]);
      apb(0, RXDATA_OFFSET, 0);
    end
    apb(1, MODE_OFFSET, (32'(FMT_NOPAR) << MODE_FMT_LSB) | (32'h1 << MODE_STOP_BIT));
    src.send(9'h05a, 8, 1);
    apb(0, STA_OFFSET, 0);
    chk("two stop framing_error_flag", 0, rd[STA_FRAMING_ERROR_FLAG_BIT]);
    apb(0, RXDATA_OFFSET, 0);
    chk("two stop data", 32'h05a, rd);
  endtask
  task automatic t_addr;
    int h;
    fmt(FMT_NINE);
    ctl(THR_ONE, 1, 0);
    h = hits;
    src.send(9'h142, 9, 1);
    src.send(9'h043, 9, 1);
    chk("addr hits", h + 1, hits);
    apb(0, RXDATA_OFFSET, 0);
    chk("nine bit", 32'h142, rd);
    apb(0, RXDATA_OFFSET, 0);
    ctl(THR_ONE, 0, 0);
    src.send(9'h142, 9, 1);
    fmt(FMT_ODD);
    ctl(THR_ONE, 1, 0);
    src.send({1'b1, 8'h80}, 9, 1);
    chk("no addr", h + 1, hits);
    apb(0, RXDATA_OFFSET, 0);
    chk("nine bit no addr", 32'h142, rd);
    apb(0, STA_OFFSET, 0);
    chk("odd parity_error_flag", 1, rd[STA_PARITY_ERROR_FLAG_BIT]);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 0;
    RST = 1;
    {PSEL, PENABLE, PWRITE} = 0;
    PADDR = 0;
    PWDATA = 0;
    repeat (12) @(posedge CLOCK);
    RST <= 0;
    t_reset();
    t_basic();
    t_fill();
    t_errors();
    t_addr();
    results();
  end
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule
`default_nettype wire
